// File: uv_pkg.sv
/*
 * Shared constants and types of the definite-time undervoltage detector:
 * register map, field positions, reset values, setting ranges and timing.
 * Assumes magnitudes arrive in units of 0.1 % of nominal voltage.
 */
package uv_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LEVELS = 8'h04;
    localparam logic [7:0] OFS_DELAY = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

    // ==========================================================
    // Field positions
    localparam int CTRL_OPSEL_LSB = 0;
    localparam int CTRL_START_ONLY_BIT = 2;
    localparam int CTRL_LINE_TO_LINE_BIT = 3;
    localparam int LEVELS_START_LSB = 0;
    localparam int LEVELS_BLOCK_LSB = 8;
    localparam int LEVELS_HYST_LSB = 16;
    localparam int IRQ_START_BIT = 0;
    localparam int IRQ_TRIP_BIT = 1;

    // ==========================================================
    // Setting ranges and reset values
    localparam logic [7:0] START_PCT_MIN = 8'h1e;
    localparam logic [7:0] START_PCT_MAX = 8'h82;
    localparam logic [7:0] START_PCT_RST = 8'h5a;
    localparam logic [7:0] BLOCK_PCT_MAX = 8'h14;
    localparam logic [7:0] BLOCK_PCT_RST = 8'h0a;
    localparam logic [7:0] HYST_PCT_MIN = 8'h01;
    localparam logic [7:0] HYST_PCT_MAX = 8'h0a;
    localparam logic [7:0] HYST_PCT_RST = 8'h05;
    localparam logic [15:0] DELAY_MS_MIN = 16'h0032;
    localparam logic [15:0] DELAY_MS_MAX = 16'hea60;
    localparam logic [15:0] DELAY_MS_RST = 16'h0064;
    localparam logic START_ONLY_RST = 1'b0;
    localparam logic LINE_TO_LINE_RST = 1'b1;

    // ==========================================================
    // Timing
    localparam int CLK_HZ = 100000000;
    localparam int MS_PER_S = 1000;
    localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        OP_OFF = 2'b00,
        OP_ONE_OF_THREE = 2'b01,
        OP_TWO_OF_THREE = 2'b10,
        OP_ALL = 2'b11
    } operation_select_t;

    typedef struct packed {
        logic [15:0] phase_c_magnitude;
        logic [15:0] phase_b_magnitude;
        logic [15:0] phase_a_magnitude;
    } magnitudes_t;

    typedef struct packed {
        logic phase_c_started;
        logic phase_b_started;
        logic phase_a_started;
    } started_t;

    typedef struct packed {
        logic [7:0] start_threshold_pct;
        logic [7:0] block_threshold_pct;
        logic [7:0] dropoff_hysteresis_pct;
    } levels_t;

endpackage

// File: uv_phase_detect.sv
/*
 * One phase's start detector with drop-off hysteresis.
 * Assumes the magnitude is synchronous to the clock and in 0.1 % units.
 */
`timescale 1ns/1ps
module uv_phase_detect (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RST_IN,
    // Settings and measurement
    input wire logic enable_in,
    input wire logic [15:0] magnitude_in,
    input wire uv_pkg::levels_t levels_in,
    // Result
    output logic started_out
);
    import uv_pkg::*;

    wire [19:0] mag_x10 = {4'h0, magnitude_in} * 20'h0000a;
    wire [19:0] start_lvl = {12'h000, levels_in.start_threshold_pct} * 20'h00064;
    wire [19:0] block_lvl = {12'h000, levels_in.block_threshold_pct} * 20'h00064;
    wire [19:0] drop_lvl = {12'h000, levels_in.start_threshold_pct} *
                           ({12'h000, levels_in.dropoff_hysteresis_pct} + 20'h00064);
    // Both sides are scaled to 0.01 % so no division is needed.
    wire above_block = mag_x10 > block_lvl;
    wire below_start = mag_x10 < start_lvl;
    wire below_drop = mag_x10 <= drop_lvl;
    wire next_started = enable_in & above_block & (started_out ? below_drop : below_start);

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            started_out <= 1'b0;
        end else begin
            started_out <= next_started;
        end
    end

    AST_BLOCK_SUPPRESS: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        !above_block |=> !started_out) else $error("start flag set at or below blocking level");
    AST_HYST_HOLD: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        started_out && enable_in && above_block && below_drop |=> started_out)
        else $error("start flag dropped inside hysteresis band");
endmodule

// File: undervoltage_function.sv
/*
 * Three-phase definite-time undervoltage detector with an APB register file,
 * sticky interrupt status and a millisecond trip timer.
 * Assumes magnitudes and the block input come from logic on CLK_IN.
 */
// Local design decisions: the APB interface to the registers and the register offsets.
// Contract
// - A phase starts while its magnitude is below the start level and above the blocking level.
// - The general start output is high whenever any phase meets its start condition.
// - Trip is issued only after the full delay with the condition held, and never in start-only mode.
// - The operation selector offers off, one of three, two of three and all, and resets to off.
// - The start level is a percentage from 30 to 130 in steps of 1, default 90.
// - The blocking level is a percentage from 0 to 20, default 10, and suppresses start below it.
// - The start-only option defaults to 0, which lets trips be generated.
// - The trip delay is set in milliseconds from 50 to 60000, default 100.
// - Operating time equals the delay setting regardless of how deep the voltage has fallen.
// - In phase-to-phase use the three flags stand for the pairs 12, 23 and 31.
// - Per-phase trips stay internal and only the combined trip leaves the block.
// - Phase-to-phase magnitudes are evaluated by default.
// - General start is the OR of starts; combined trip is the OR of trips gated by not blocked and not start-only.
`timescale 1ns/1ps
module undervoltage_function #(
    parameter int CYCLES_PER_MS_P = uv_pkg::CYCLES_PER_MS
) (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RST_IN,
    // APB slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // Measurements from the Fourier stage
    input wire uv_pkg::magnitudes_t PHASE_MAG_IN,
    input wire uv_pkg::magnitudes_t LINE_MAG_IN,
    input wire logic FUNCTION_BLOCK_IN,
    // Protection outputs
    output uv_pkg::started_t PHASE_STARTED_OUT,
    output logic ANY_PHASE_STARTED_OUT,
    output logic COMBINED_TRIP_OUT,
    output logic IRQ_OUT
);
    import uv_pkg::*;

    // ==========================================================
    // Settings and interrupt registers
    operation_select_t operation_select;
    logic start_only_option;
    logic line_to_line;
    levels_t levels;
    logic [15:0] trip_delay_ms;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;

    // ==========================================================
    // APB decode
    wire apb_access = PSEL_IN & PENABLE_IN & PREADY_OUT;
    wire apb_wr = apb_access & PWRITE_IN;
    wire hit_ctrl = PADDR_IN == OFS_CTRL;
    wire hit_levels = PADDR_IN == OFS_LEVELS;
    wire hit_delay = PADDR_IN == OFS_DELAY;
    wire hit_status = PADDR_IN == OFS_STATUS;
    wire hit_istat = PADDR_IN == OFS_IRQ_STAT;
    wire hit_imask = PADDR_IN == OFS_IRQ_MASK;
    wire mapped = hit_ctrl | hit_levels | hit_delay | hit_status | hit_istat | hit_imask;

    wire [7:0] wr_start = PWDATA_IN[LEVELS_START_LSB +: 8];
    wire [7:0] wr_block = PWDATA_IN[LEVELS_BLOCK_LSB +: 8];
    wire [7:0] wr_hyst = PWDATA_IN[LEVELS_HYST_LSB +: 8];
    wire [15:0] wr_delay = PWDATA_IN[15:0];
    // Out-of-range settings are refused whole so the detector never runs on a half-valid set.
    wire levels_ok = wr_start >= START_PCT_MIN && wr_start <= START_PCT_MAX &&
                     wr_block <= BLOCK_PCT_MAX &&
                     wr_hyst >= HYST_PCT_MIN && wr_hyst <= HYST_PCT_MAX;
    wire delay_ok = wr_delay >= DELAY_MS_MIN && wr_delay <= DELAY_MS_MAX;
    wire bad_value = (hit_levels & ~levels_ok) | (hit_delay & ~delay_ok);
    wire next_slverr = ~mapped | (PWRITE_IN & (bad_value | hit_status));

    // ==========================================================
    // Detection
    started_t started;
    logic timer_done;
    logic [31:0] pre_count;
    logic [15:0] ms_count;
    wire enabled = operation_select != OP_OFF && !FUNCTION_BLOCK_IN;
    wire magnitudes_t mags = line_to_line ? LINE_MAG_IN : PHASE_MAG_IN;

    uv_phase_detect phase_a_det (
        .CLK_IN(CLK_IN),
        .RST_IN(RST_IN),
        .enable_in(enabled),
        .magnitude_in(mags.phase_a_magnitude),
        .levels_in(levels),
        .started_out(started.phase_a_started)
    );
    uv_phase_detect phase_b_det (
        .CLK_IN(CLK_IN),
        .RST_IN(RST_IN),
        .enable_in(enabled),
        .magnitude_in(mags.phase_b_magnitude),
        .levels_in(levels),
        .started_out(started.phase_b_started)
    );
    uv_phase_detect phase_c_det (
        .CLK_IN(CLK_IN),
        .RST_IN(RST_IN),
        .enable_in(enabled),
        .magnitude_in(mags.phase_c_magnitude),
        .levels_in(levels),
        .started_out(started.phase_c_started)
    );

    wire [1:0] n_started = {1'b0, started.phase_a_started} + {1'b0, started.phase_b_started} +
                           {1'b0, started.phase_c_started};
    wire any_started = |started;
    wire qualified = enabled && ((operation_select == OP_ONE_OF_THREE && n_started >= 2'd1) ||
                                 (operation_select == OP_TWO_OF_THREE && n_started >= 2'd2) ||
                                 (operation_select == OP_ALL && n_started == 2'd3));
    // Per-phase trips exist only here; they are never brought to a port.
    wire [2:0] phase_trip = started & {3{timer_done & qualified}};
    wire next_trip = (|phase_trip) & !FUNCTION_BLOCK_IN & !start_only_option;

    wire ms_tick = pre_count == CYCLES_PER_MS_P - 1;
    wire next_done = ms_tick && (ms_count + 16'h0001 >= trip_delay_ms);
    // The timer depends only on the delay setting, so depth of the dip has no effect.
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pre_count <= 32'h0;
            ms_count <= 16'h0;
            timer_done <= 1'b0;
        end else if (!qualified) begin
            pre_count <= 32'h0;
            ms_count <= 16'h0;
            timer_done <= 1'b0;
        end else if (!timer_done) begin
            pre_count <= ms_tick ? 32'h0 : pre_count + 32'h1;
            ms_count <= ms_tick ? ms_count + 16'h0001 : ms_count;
            timer_done <= next_done;
        end
    end

    // ==========================================================
    // Interrupt events: a new set wins over a clear in the same cycle
    wire start_rise = any_started & ~ANY_PHASE_STARTED_OUT;
    wire trip_rise = next_trip & ~COMBINED_TRIP_OUT;
    wire [1:0] events = {trip_rise, start_rise};
    wire [1:0] w1c = (apb_wr & hit_istat) ? PWDATA_IN[1:0] : 2'b00;
    wire [1:0] next_irq_stat = (irq_stat & ~w1c) | events;

    // ==========================================================
    // Read mux
    wire [31:0] rd_ctrl = {28'h0, line_to_line, start_only_option, operation_select};
    wire [31:0] rd_levels = {8'h00, levels.dropoff_hysteresis_pct, levels.block_threshold_pct,
                             levels.start_threshold_pct};
    wire [31:0] rd_status = {26'h0, qualified, COMBINED_TRIP_OUT, ANY_PHASE_STARTED_OUT, started};
    wire [31:0] next_rdata = hit_ctrl ? rd_ctrl :
                             hit_levels ? rd_levels :
                             hit_delay ? {16'h0, trip_delay_ms} :
                             hit_status ? rd_status :
                             hit_istat ? {30'h0, irq_stat} :
                             hit_imask ? {30'h0, irq_mask} : 32'h0;
    wire setup_done = PSEL_IN & PENABLE_IN & ~PREADY_OUT;

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT <= 32'h0;
        end else begin
            PREADY_OUT <= setup_done;
            PSLVERR_OUT <= setup_done & next_slverr;
            PRDATA_OUT <= (setup_done & ~PWRITE_IN) ? next_rdata : 32'h0;
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            operation_select <= OP_OFF;
            start_only_option <= START_ONLY_RST;
            line_to_line <= LINE_TO_LINE_RST;
        end else if (apb_wr && hit_ctrl) begin
            operation_select <= operation_select_t'(PWDATA_IN[CTRL_OPSEL_LSB +: 2]);
            start_only_option <= PWDATA_IN[CTRL_START_ONLY_BIT];
            line_to_line <= PWDATA_IN[CTRL_LINE_TO_LINE_BIT];
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            levels <= '{START_PCT_RST, BLOCK_PCT_RST, HYST_PCT_RST};
            trip_delay_ms <= DELAY_MS_RST;
        end else begin
            if (apb_wr && hit_levels && levels_ok) begin
                levels <= '{wr_start, wr_block, wr_hyst};
            end
            if (apb_wr && hit_delay && delay_ok) begin
                trip_delay_ms <= wr_delay;
            end
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            irq_stat <= 2'b00;
            irq_mask <= 2'b00;
            IRQ_OUT <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            irq_mask <= (apb_wr && hit_imask) ? PWDATA_IN[1:0] : irq_mask;
            IRQ_OUT <= |(next_irq_stat & irq_mask);
        end
    end

    // ==========================================================
    // Outputs
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            PHASE_STARTED_OUT <= '0;
            ANY_PHASE_STARTED_OUT <= 1'b0;
            COMBINED_TRIP_OUT <= 1'b0;
        end else begin
            PHASE_STARTED_OUT <= started & {3{enabled}};
            ANY_PHASE_STARTED_OUT <= any_started & enabled;
            COMBINED_TRIP_OUT <= next_trip;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    AST_GENERAL_START: assert property (ANY_PHASE_STARTED_OUT == $past(any_started & enabled))
        else $error("general start does not follow the phase starts");
    AST_TRIP_NEEDS_DONE: assert property (COMBINED_TRIP_OUT |-> $past(timer_done & qualified))
        else $error("trip without expired delay");
    AST_START_ONLY: assert property (start_only_option |=> !COMBINED_TRIP_OUT)
        else $error("trip issued in start-only mode");
    AST_BLOCK_CLEARS: assert property (FUNCTION_BLOCK_IN |=> !COMBINED_TRIP_OUT && !ANY_PHASE_STARTED_OUT)
        else $error("outputs active while blocked");
    AST_OFF_QUIET: assert property (operation_select == OP_OFF |=> PHASE_STARTED_OUT == '0)
        else $error("start flags while function is off");
    AST_TIMER_CLEAR: assert property (!qualified |=> ms_count == 16'h0 && !timer_done)
        else $error("timer not cleared on loss of qualification");
    AST_DELAY_FULL: assert property ($rose(timer_done) |-> ms_count == trip_delay_ms)
        else $error("delay ended at the wrong millisecond");
    AST_DELAY_RANGE: assert property (trip_delay_ms >= DELAY_MS_MIN && trip_delay_ms <= DELAY_MS_MAX)
        else $error("delay setting out of range");
    AST_START_RANGE: assert property (levels.start_threshold_pct >= START_PCT_MIN &&
                                      levels.start_threshold_pct <= START_PCT_MAX)
        else $error("start level out of range");
    AST_TWO_OF_THREE: assert property (operation_select == OP_TWO_OF_THREE && n_started < 2'd2
                                       |-> !qualified)
        else $error("two-of-three qualified with fewer phases");

    COV_START: cover property ($rose(ANY_PHASE_STARTED_OUT));
    COV_TRIP: cover property ($rose(COMBINED_TRIP_OUT));
    COV_DROP: cover property (ANY_PHASE_STARTED_OUT ##1 !ANY_PHASE_STARTED_OUT);
    COV_IRQ: cover property ($rose(IRQ_OUT));
endmodule

// File: mag_source.sv
/*
 * Model of the stage in front of the detector: the magnitude calculation and
 * the user logic that drives the block input.
 * Assumes the bench gives its commands on the same clock as the detector.
 */
`timescale 1ns/1ps
module mag_source (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Commands from the bench
    input wire uv_pkg::magnitudes_t phase_cmd_in,
    input wire uv_pkg::magnitudes_t line_cmd_in,
    input wire logic block_cmd_in,
    // Towards the detector
    output uv_pkg::magnitudes_t phase_mag_out,
    output uv_pkg::magnitudes_t line_mag_out,
    output logic block_out
);
    import uv_pkg::*;
    // ==========================================================
    // One cycle of latency stands for the magnitude calculation.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            phase_mag_out <= '0;
            line_mag_out <= '0;
            block_out <= 1'b0;
        end else begin
            phase_mag_out <= phase_cmd_in;
            line_mag_out <= line_cmd_in;
            block_out <= block_cmd_in;
        end
    end
endmodule

// File: tb.sv
/*
 * Self-checking bench of the undervoltage detector: registers over APB,
 * start thresholds with corner and random magnitudes, trip timing, interrupts.
 * Assumes a shortened millisecond of 4 cycles.
 */
`timescale 1ns/1ps
module tb;
    import uv_pkg::*;
    localparam int P = 4;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, blk_cmd, blk, any_st, trip, irq, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    magnitudes_t phase_cmd, line_cmd, phase_mag, line_mag;
    started_t started;
    logic [2:0] st;
    int fail_count, cmp_count;
    int m[3];
    int n[2];
    int corner[8] = '{101, 100, 899, 945, 946, 945, 900, 0};
    logic t_w[14] = '{0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 0, 0};
    logic t_e[14] = '{0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 0, 0};
    logic [7:0] t_a[14] = '{OFS_CTRL, OFS_LEVELS, OFS_DELAY, OFS_IRQ_STAT, OFS_IRQ_MASK, 8'h18, OFS_STATUS,
        OFS_LEVELS, OFS_DELAY, OFS_DELAY, OFS_LEVELS, OFS_LEVELS, OFS_DELAY, OFS_LEVELS};
    logic [31:0] t_d[14] = '{0, 0, 0, 0, 0, 0, 32'h1, 32'h00050a1d, 32'h31, 32'hea61, 32'h0005155a,
        32'h000b0a5a, 0, 0};
    logic [31:0] t_r[14] = '{32'h8, 32'h00050a5a, 32'h64, 0, 0, 0, 0, 0, 0, 0, 0, 0, 32'h64, 32'h00050a5a};

    mag_source mag_source_i (.clk_in(clk), .rst_in(rst), .phase_cmd_in(phase_cmd), .line_cmd_in(line_cmd),
        .block_cmd_in(blk_cmd), .phase_mag_out(phase_mag), .line_mag_out(line_mag), .block_out(blk));
    undervoltage_function #(.CYCLES_PER_MS_P(P)) undervoltage_function_i (.CLK_IN(clk), .RST_IN(rst),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PHASE_MAG_IN(phase_mag),
        .LINE_MAG_IN(line_mag), .FUNCTION_BLOCK_IN(blk), .PHASE_STARTED_OUT(started),
        .ANY_PHASE_STARTED_OUT(any_st), .COMBINED_TRIP_OUT(trip), .IRQ_OUT(irq));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Pready, read data and error are taken at the rising edge that completes the access, before its updates land.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
        output logic er);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            fail_count++;
            wrap_up();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, r, e);
    endtask

    task automatic dip(input int c, input int b, input int a, input int wait_n);
        @(posedge clk);
        phase_cmd <= {16'(c), 16'(b), 16'(a)};
        repeat (wait_n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic trip_wait(output int k);
        k = 0;
        while (trip !== 1'b1 && k < 400) begin
            @(negedge clk);
            k++;
        end
        if (k >= 400) begin
            fail_count++;
            wrap_up();
        end
    endtask

    // Start state of one phase at the reset levels, with drop-off hysteresis.
    function automatic logic exp_st(input int mg, input logic prev);
        if (mg * 10 <= int'(BLOCK_PCT_RST) * 100)
            return 1'b0;
        if (prev)
            return mg * 10 <= int'(START_PCT_RST) * (100 + int'(HYST_PCT_RST));
        return mg * 10 < int'(START_PCT_RST) * 100;
    endfunction

    // ==========================================================
    // Main sequence
    initial begin
        {psel, penable, pwrite, blk_cmd, paddr, pwdata} = '0;
        phase_cmd = {3{16'h03e8}};
        line_cmd = {3{16'h03e8}};
        fail_count = 0;
        cmp_count = 0;
        st = '0;
        rst = 1'b1;
        void'($urandom(32'h6262));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 14; i++) begin
            apb(t_w[i], t_a[i], t_d[i], r, e);
            chk(32'(e), 32'(t_e[i]));
            if (!t_w[i]) chk(r, t_r[i]);
        end
        dip(500, 500, 500, 6);
        chk(32'(started), 0);
        wr(OFS_CTRL, 32'h5);
        for (int i = 0; i < 40; i++) begin
            for (int p = 0; p < 3; p++) begin
                m[p] = (i < 8) ? corner[i] : $urandom_range(1400, 0);
                st[p] = exp_st(m[p], st[p]);
            end
            dip(m[2], m[1], m[0], 5);
            chk(32'(started), 32'(st));
            chk(32'(any_st), 32'(|st));
            chk(32'(trip), 0);
        end
        // Switching off first clears the timer, so a shorter delay never meets a count already past it.
        wr(OFS_CTRL, 32'h0);
        wr(OFS_DELAY, 32'd50);
        wr(OFS_IRQ_MASK, 32'h3);
        wr(OFS_CTRL, 32'h2);
        dip(1000, 1000, 500, 260);
        chk(32'(trip), 0);
        for (int k = 0; k < 2; k++) begin
            dip(1000, 1000, 1000, 5);
            dip(1000, 1000, 500, 4);
            @(posedge clk);
            phase_cmd <= {16'h03e8, (k == 0) ? 16'd150 : 16'd850, 16'h01f4};
            trip_wait(n[k]);
            chk(32'(n[k] >= P * 50 && n[k] <= P * 50 + 12), 1);
            repeat (3) @(negedge clk);
            chk(32'(irq), 1);
            apb(1'b0, OFS_IRQ_STAT, 0, r, e);
            chk(r, 32'h3);
            wr(OFS_IRQ_STAT, 32'h3);
            apb(1'b0, OFS_IRQ_STAT, 0, r, e);
            chk(r, 0);
            chk(32'(irq), 0);
            dip(1000, 1000, 500, 5);
            chk(32'(trip), 0);
        end
        chk(n[0], n[1]);
        wr(OFS_CTRL, 32'h6);
        dip(1000, 500, 500, 260);
        chk(32'(trip), 0);
        wr(OFS_CTRL, 32'h3);
        dip(500, 500, 500, 3);
        trip_wait(n[0]);
        chk(32'(trip), 1);
        @(posedge clk);
        blk_cmd <= 1'b1;
        repeat (5) @(negedge clk);
        chk(32'({trip, any_st, started}), 0);
        @(posedge clk);
        blk_cmd <= 1'b0;
        wr(OFS_CTRL, 32'h9);
        @(posedge clk);
        line_cmd <= {16'h03e8, 16'h03e8, 16'h01f4};
        repeat (6) @(negedge clk);
        chk(32'(started), 32'h1);
        wrap_up();
    end
endmodule
